// ---- bench/motor_control_maint_regs_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module motor_control_maint_regs_tb;
  logic clock, srst, hsel, hwrite, hready, hreadyout, hresp, brake_engage, cal_done;
  logic [7:0] haddr;
  logic [1:0] htrans, kk;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, current_position, rd, v, s;
  logic [15:0] measured_speed;
  logic [31:0] img [0:14];
  motor_regs_pkg::motor_cfg_t motor_cfg;
  motor_regs_pkg::motion_t motion;
  motor_regs_pkg::maint_cfg_t maint_cfg;
  motor_regs_pkg::maint_stat_t maint_stat;
  int errors, comparisons, cycles;
  int seed = 32'h06d28d80;
  assign hready = hreadyout;
  motor_control_maint_regs i_motor_control_maint_regs (.clock(clock), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .motor_cfg(motor_cfg), .motion(motion), .brake_engage(brake_engage),
    .current_position(current_position), .measured_speed(measured_speed),
    .maint_cfg(maint_cfg), .maint_stat(maint_stat));
  motor_side_model i_motor_side_model (.clock(clock), .srst(srst), .maint_cfg(maint_cfg),
    .maint_stat(maint_stat));
  // ---------------------------------------------------------------
  // bus tasks and expectations
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {hsel, hwrite, htrans, haddr} = {2'b11, 2'h2, a};
    @(negedge clock);
    {hsel, htrans, hwdata} = {1'b0, 2'h0, d};
    @(negedge clock);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    int n = 0;
    {hsel, hwrite, htrans, haddr} = {2'b10, 2'h2, a};
    @(negedge clock);
    {hsel, htrans} = 3'h0;
    while (hreadyout !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    d = hrdata;
    @(negedge clock);
  endtask
  function automatic logic [31:0] exp_rd(input int i);
    case (i)
      9: return current_position;
      10: return {16'h0000, measured_speed};
      11: return 32'h0;
      14: return {28'h0, 1'b1, cal_done, 2'b00};
      default: return img[i];
    endcase
  endfunction
  function automatic logic [255:0] exp_cfg();
    logic [15:0] sd;
    sd = (img[7][15:0] == 16'h0) ? 16'h0078 : img[7][15:0];
    return {img[0][15:0], img[0][23:16], img[0][31:24], img[1][15:0], img[2][15:0],
      img[2][31:16], img[3][15:0], img[3][31:16], img[4][15:0], img[4][31:16],
      img[5][31:16], img[6][26], (img[6][26] ? 10'h0 : img[5][9:0]),
      (img[6][26] ? img[5][15:0] : 16'h0), img[6][24], sd, img[7][15:0], img[8],
      img[6][29], img[6][30]};
  endfunction
  task automatic sweep();
    for (int i = 0; i < 15; i++) begin
      rd_reg(8'(i * 4), rd);
      chk("register", exp_rd(i), rd);
    end
    rd_reg(8'h3c, rd);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 1'b0, hresp);
  endtask
  task automatic rand_fill();
    for (int i = 0; i < 15; i++) begin
      v = $random(seed);
      v = (i == 6) ? (v & 32'h77ff_ffff) : v;
      wr(8'(i * 4), v);
      if (!(i inside {9, 10, 11, 14})) img[i] = v;
    end
    current_position = $random(seed);
    measured_speed = 16'($random(seed));
  endtask
  task automatic commit_cfg();
    wr(8'h18, s);
    img[6] = s;
    rd_reg(8'h18, rd);
    wr(8'h18, rd | 32'h8000_0000);
    repeat (4) @(negedge clock);
  endtask
  task automatic give_verdict();
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    {srst, hsel, hwrite, htrans, haddr, hsize, hwdata} = {5'h10, 8'h00, 3'h2, 32'h0};
    {current_position, measured_speed, cal_done} = {32'h0, 16'h0, 1'b0};
    for (int i = 0; i < 15; i++) img[i] = 32'h0;
    repeat (8) @(negedge clock);
    srst = 1'b0;
    sweep();
    for (int r = 0; r < 3; r++) begin
      rand_fill();
      sweep();
    end
    chk("config before commit", 256'h0, motor_cfg);
    for (int k = 0; k < 4; k++) begin
      kk = 2'(k);
      rand_fill();
      if (kk == 2'h2) wr(8'h1c, 32'h0);
      if (kk == 2'h2) img[7] = 32'h0;
      if (kk == 2'h3) wr(8'h30, 32'h0000_0f40);
      if (kk == 2'h3) img[12] = 32'h0000_0f40;
      v = $random(seed);
      s = {1'b0, v[1:0], kk[0], 1'b0, kk[0], kk[1], v[2], kk, 22'd200};
      commit_cfg();
      chk("motion early", (kk == 2'h1) ? 2'b00 : {kk[0], kk[1]}, motion);
      chk("config", exp_cfg(), motor_cfg);
      chk("maint config", {img[12][6], img[12][7], img[12][15:8], (img[12][31:16] == 16'h0 ?
        17'h10000 : {1'b0, img[12][31:16]}), img[13]}, maint_cfg);
      repeat (25) @(negedge clock);
      chk("motion", {kk[0], kk[1]}, motion);
      cal_done = cal_done | img[12][6];
      sweep();
    end
    chk("brake idle", 1'b0, brake_engage);
    wr(8'h18, img[6] | 32'h0800_0000);
    @(negedge clock);
    chk("brake", 1'b1, brake_engage);
    chk("config kept", exp_cfg(), motor_cfg);
    hsize = 3'h0;
    wr(8'h02, 32'h005a_0000);
    hsize = 3'h1;
    wr(8'h00, 32'h0000_c3a5);
    hsize = 3'h2;
    img[0][23:0] = 24'h5ac3a5;
    rd_reg(8'h00, rd);
    chk("lane write", img[0], rd);
    give_verdict();
  end
endmodule // motor_control_maint_regs_tb
`default_nettype wire

// ---- bench/motor_side_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module motor_side_model (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // active maintenance settings
  input wire motor_regs_pkg::maint_cfg_t maint_cfg,
  // collector status
  output var motor_regs_pkg::maint_stat_t maint_stat
);
  // ---------------------------------------------------------------
  // offset calibration
  // ---------------------------------------------------------------
  // the counter saturates so a calibrate level held high gives one pulse only
  logic [2:0] cal_cnt_q;
  always_ff @(posedge clock) begin
    if (srst || !maint_cfg.offset_calibrate) begin
      cal_cnt_q <= 3'h0;
    end else if (cal_cnt_q != 3'h7) begin
      cal_cnt_q <= cal_cnt_q + 3'h1;
    end
  end
  assign maint_stat = {1'b0, 1'b0, 1'b1, cal_cnt_q == 3'h6, 16'h0000};
endmodule // motor_side_model
`default_nettype wire

// ---- src/motor_control_maint_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module motor_control_maint_regs (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // ahb-lite subordinate
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // motor logic
  output var motor_regs_pkg::motor_cfg_t motor_cfg,
  output var motor_regs_pkg::motion_t motion,
  output logic brake_engage,
  input wire logic [31:0] current_position,
  input wire logic [15:0] measured_speed,
  // maintenance collector
  output var motor_regs_pkg::maint_cfg_t maint_cfg,
  input wire motor_regs_pkg::maint_stat_t maint_stat
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic [2:0] size, input logic [1:0] a);
    logic [31:0] m;
    m = 32'h0000_0000;
    case (size)
      3'h0: m[8*a +: 8] = 8'hff;
      3'h1: m[16*a[1] +: 16] = 16'hffff;
      default: m = 32'hffff_ffff;
    endcase
    return m;
  endfunction

  function automatic logic writable(input logic [3:0] idx);
    return (idx <= motor_regs_pkg::OFS_TARGET_POSITION[5:2]) ||
           (idx == motor_regs_pkg::OFS_MAINT_MAIN[5:2]) ||
           (idx == motor_regs_pkg::OFS_MAINT_AUX[5:2]);
  endfunction

  logic [31:0] hold_q [motor_regs_pkg::REG_COUNT];
  logic [3:0] addr_q;
  logic mapped_q;
  logic wr_q;
  logic rd_q;
  logic [31:0] mask_q;
  logic [31:0] hrdata_q;

  wire logic taken = hsel && hready && htrans[1];
  wire logic [3:0] addr_idx = haddr[5:2];
  wire logic addr_mapped = (haddr[7:6] == 2'h0) && (addr_idx < 4'(motor_regs_pkg::REG_COUNT));
  wire logic [3:0] sync_idx = motor_regs_pkg::OFS_SYNC_CONTROL[5:2];
  wire logic wr_now = wr_q && mapped_q && writable(addr_q);
  wire logic [31:0] sync_hold = hold_q[sync_idx];
  wire logic [31:0] maint_hold = hold_q[motor_regs_pkg::OFS_MAINT_MAIN[5:2]];

  // reads wait one cycle so a write just before them is already stored
  assign hreadyout = !rd_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 4'h0;
      mapped_q <= 1'b0;
      mask_q <= 32'h0000_0000;
    end else if (hreadyout) begin
      wr_q <= taken && hwrite;
      rd_q <= taken && !hwrite;
      addr_q <= addr_idx;
      mapped_q <= addr_mapped;
      mask_q <= lane_mask(hsize, haddr[1:0]);
    end else begin
      rd_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // commit handshake
  // ---------------------------------------------------------------
  logic commit_req_q;
  logic commit_ack_q;
  wire logic commit_apply = commit_req_q && !commit_ack_q;

  // the commit bit is held until the active side has taken the copy
  wire logic commit_written = wr_now && (addr_q == sync_idx) &&
                              mask_q[motor_regs_pkg::BIT_COMMIT] &&
                              hwdata[motor_regs_pkg::BIT_COMMIT];

  always_ff @(posedge clock) begin
    if (srst) begin
      commit_req_q <= 1'b0;
      commit_ack_q <= 1'b0;
    end else begin
      commit_req_q <= (commit_req_q && !commit_ack_q) || commit_written;
      commit_ack_q <= commit_apply;
    end
  end

  // ---------------------------------------------------------------
  // holding registers
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < motor_regs_pkg::REG_COUNT; gi++) begin : g_hold
      wire logic self_clear = (gi == sync_idx) && commit_ack_q && !commit_written;
      always_ff @(posedge clock) begin
        if (srst) begin
          hold_q[gi] <= motor_regs_pkg::REG_RESET;
        end else if (wr_now && addr_q == 4'(gi)) begin
          hold_q[gi] <= (hold_q[gi] & ~mask_q) | (hwdata & mask_q);
        end else if (self_clear) begin
          hold_q[gi][motor_regs_pkg::BIT_COMMIT] <= 1'b0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // status and read mux
  // ---------------------------------------------------------------
  logic cal_done_q;
  logic calibrate_prev_q;
  wire logic calibrate_start = maint_cfg.offset_calibrate && !calibrate_prev_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      cal_done_q <= 1'b0;
      calibrate_prev_q <= 1'b0;
    end else begin
      calibrate_prev_q <= maint_cfg.offset_calibrate;
      // a completion in the same cycle as a new start still counts
      cal_done_q <= maint_stat.offset_calibrate_done_pulse || (cal_done_q && !calibrate_start);
    end
  end

  wire logic [31:0] maint_status_word = {maint_stat.rotation_count, 12'h000,
                                         maint_stat.collect_ready, cal_done_q,
                                         maint_stat.collect_busy, maint_stat.collect_done};
  logic [31:0] read_word;
  always_comb begin
    read_word = 32'h0000_0000;
    if (mapped_q) begin
      if (writable(addr_q)) begin
        read_word = hold_q[addr_q];
      end else if (addr_q == motor_regs_pkg::OFS_CURRENT_POSITION[5:2]) begin
        read_word = current_position;
      end else if (addr_q == motor_regs_pkg::OFS_SPEED_STATUS[5:2]) begin
        read_word = {16'h0000, measured_speed};
      end else if (addr_q == motor_regs_pkg::OFS_MAINT_STATUS[5:2]) begin
        read_word = maint_status_word;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_q) begin
      hrdata_q <= read_word;
    end
  end

  // ---------------------------------------------------------------
  // active registers
  // ---------------------------------------------------------------
  motor_regs_pkg::motor_cfg_t cfg_q;
  motor_regs_pkg::maint_cfg_t maint_q;
  motor_regs_pkg::motor_cfg_t cfg_d;
  motor_regs_pkg::maint_cfg_t maint_d;

  wire logic [31:0] w_start = hold_q[motor_regs_pkg::OFS_START_CONFIG[5:2]];
  wire logic [31:0] w_limit = hold_q[motor_regs_pkg::OFS_SPEED_LIMIT[5:2]];
  wire logic [31:0] w_sint = hold_q[motor_regs_pkg::OFS_SPEED_INTEGRAL[5:2]];
  wire logic [31:0] w_sprop = hold_q[motor_regs_pkg::OFS_SPEED_PROPORTIONAL[5:2]];
  wire logic [31:0] w_tint = hold_q[motor_regs_pkg::OFS_TORQUE_INTEGRAL[5:2]];
  wire logic [31:0] w_tprop = hold_q[motor_regs_pkg::OFS_TORQUE_PROPORTIONAL[5:2]];
  wire logic [31:0] w_tspd = hold_q[motor_regs_pkg::OFS_TARGET_SPEED[5:2]];
  wire logic torque_sel = sync_hold[motor_regs_pkg::BIT_TORQUE_SELECT];
  wire logic speed_clear = sync_hold[motor_regs_pkg::BIT_SPEED_CLEAR];

  always_comb begin
    cfg_d.start_speed = w_start[15:0];
    cfg_d.stator_pole_count = w_start[23:16];
    cfg_d.speed_loop_update_rate = w_start[31:24];
    cfg_d.speed_ceiling = w_limit[15:0];
    cfg_d.speed_integral_gain = w_sint[15:0];
    cfg_d.speed_antiwindup_threshold = w_sint[31:16];
    cfg_d.speed_proportional_gain = w_sprop[15:0];
    cfg_d.speed_antiwindup_clamp = w_sprop[31:16];
    cfg_d.torque_integral_gain = w_tint[15:0];
    cfg_d.torque_antiwindup_threshold = w_tint[31:16];
    cfg_d.torque_antiwindup_clamp = w_tprop[31:16];
    cfg_d.torque_loop_select = torque_sel;
    cfg_d.motor_power = torque_sel ? 10'h000 : w_tprop[9:0];
    cfg_d.torque_proportional_gain = torque_sel ? w_tprop[15:0] : 16'h0000;
    cfg_d.speed_loop_clear = speed_clear;
    cfg_d.speed_loop_seed = (w_tspd[15:0] == 16'h0000) ?
                            motor_regs_pkg::SPEED_SEED_DEFAULT_RPM : w_tspd[15:0];
    cfg_d.target_speed = w_tspd[15:0];
    cfg_d.target_position = hold_q[motor_regs_pkg::OFS_TARGET_POSITION[5:2]];
    cfg_d.motion_mode_select = sync_hold[motor_regs_pkg::BIT_MOTION_MODE];
    cfg_d.direction_ccw = sync_hold[motor_regs_pkg::BIT_DIRECTION];
    maint_d.offset_calibrate = maint_hold[motor_regs_pkg::BIT_CALIBRATE];
    maint_d.adc_quantity_select = maint_hold[motor_regs_pkg::BIT_QUANTITY];
    maint_d.settle_revolutions = maint_hold[15:8];
    maint_d.capture_revolutions = (maint_hold[31:16] == 16'h0000) ?
                                  motor_regs_pkg::CAPTURE_ZERO_MEANS :
                                  {1'b0, maint_hold[31:16]};
    maint_d.aux = hold_q[motor_regs_pkg::OFS_MAINT_AUX[5:2]];
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_q <= '0;
      maint_q <= '0;
    end else if (commit_apply) begin
      cfg_q <= cfg_d;
      maint_q <= maint_d;
    end
  end

  assign motor_cfg = cfg_q;
  assign maint_cfg = maint_q;

  // ---------------------------------------------------------------
  // sync delay before start and stop
  // ---------------------------------------------------------------
  typedef enum logic {SYNC_IDLE, SYNC_WAIT} sync_state_t;
  sync_state_t sync_state_q;
  logic [21:0] delay_ns_q;
  logic [22:0] elapsed_ns_q;
  motor_regs_pkg::motion_t pending_q;
  motor_regs_pkg::motion_t motion_q;
  motor_regs_pkg::motion_t motion_d;
  logic brake_q;

  wire logic [1:0] scale = sync_hold[motor_regs_pkg::SYNC_SCALE_LSB +: 2];
  wire logic [21:0] delay_field = sync_hold[motor_regs_pkg::SYNC_DELAY_MSB:0];
  // reserved scale codes fall back to no delay
  wire logic delay_used = (scale == motor_regs_pkg::SCALE_NANOSEC) &&
                          (delay_field != 22'h000000);
  wire logic [22:0] elapsed_next = elapsed_ns_q + motor_regs_pkg::CLOCK_PERIOD_NS;
  wire logic delay_over = elapsed_next >= {1'b0, delay_ns_q};

  assign motion_d.drive_enable = sync_hold[motor_regs_pkg::BIT_DRIVE_ENABLE];
  assign motion_d.hold_position = sync_hold[motor_regs_pkg::BIT_HOLD];

  always_ff @(posedge clock) begin
    if (srst) begin
      sync_state_q <= SYNC_IDLE;
      delay_ns_q <= 22'h000000;
      elapsed_ns_q <= 23'h000000;
      pending_q <= '0;
      motion_q <= '0;
    end else begin
      case (sync_state_q)
        SYNC_IDLE: begin
          if (commit_apply && delay_used) begin
            sync_state_q <= SYNC_WAIT;
            delay_ns_q <= delay_field;
            elapsed_ns_q <= 23'h000000;
            pending_q <= motion_d;
          end else if (commit_apply) begin
            motion_q <= motion_d;
          end
        end
        SYNC_WAIT: begin
          elapsed_ns_q <= elapsed_next;
          if (delay_over) begin
            motion_q <= pending_q;
            sync_state_q <= SYNC_IDLE;
          end
        end
        default: sync_state_q <= SYNC_IDLE;
      endcase
    end
  end

  // the halt acts on the holding copy directly: no commit, no delay
  always_ff @(posedge clock) begin
    if (srst) begin
      brake_q <= 1'b0;
    end else begin
      brake_q <= sync_hold[motor_regs_pkg::BIT_HALT];
    end
  end

  assign motion = motion_q;
  assign brake_engage = brake_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  logic [22:0] wait_cycles_q;
  logic [22:0] expected_cycles_q;
  always_ff @(posedge clock) begin
    if (srst || sync_state_q == SYNC_IDLE) begin
      wait_cycles_q <= 23'h000000;
    end else begin
      wait_cycles_q <= wait_cycles_q + 23'h000001;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      expected_cycles_q <= 23'h000000;
    end else if (commit_apply) begin
      expected_cycles_q <= 23'(({1'b0, delay_field} + motor_regs_pkg::CLOCK_PERIOD_NS
                          - 23'h000001) / motor_regs_pkg::CLOCK_PERIOD_NS);
    end
  end

  a_halt_without_commit: assert property (
    $rose(sync_hold[motor_regs_pkg::BIT_HALT]) |=> brake_engage)
    else $error("halt did not reach the brake in one cycle");
  a_active_stays: assert property (
    !commit_apply |=> $stable(cfg_q) && $stable(maint_q))
    else $error("active registers changed without commit");
  a_commit_copies: assert property (
    commit_apply |=> motor_cfg.target_speed == $past(w_tspd[15:0]))
    else $error("commit did not copy target speed");
  a_no_delay_apply: assert property (
    commit_apply && !delay_used && sync_state_q == SYNC_IDLE |=>
    motion == $past(motion_d))
    else $error("undelayed commit did not apply motion at once");
  a_delay_length: assert property (
    sync_state_q == SYNC_WAIT ##1 sync_state_q == SYNC_IDLE |->
    wait_cycles_q == expected_cycles_q && $past(wait_cycles_q) + 23'h000001 == expected_cycles_q)
    else $error("sync delay length wrong");
  a_seed_default: assert property (
    commit_apply && w_tspd[15:0] == 16'h0000 |=>
    motor_cfg.speed_loop_seed == motor_regs_pkg::SPEED_SEED_DEFAULT_RPM)
    else $error("speed seed did not default to 120 rpm");
  a_power_mode: assert property (
    !motor_cfg.torque_loop_select |-> motor_cfg.torque_proportional_gain == 16'h0000)
    else $error("open loop carries a torque gain");
  a_offset_calibrate_sticky: assert property (
    maint_stat.offset_calibrate_done_pulse |=> cal_done_q [*2] or (cal_done_q && calibrate_start))
    else $error("calibration complete flag lost");
  a_read_wait: assert property (
    taken && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("read wait state missing");

endmodule // motor_control_maint_regs
`default_nettype wire

// ---- src/motor_regs_pkg.sv ----
// Operation
// - start configuration holds start speed, stator pole count and speed-loop update rate
// - speed-limit register holds the speed ceiling in the low half
// - speed loop gains in low halves, anti-windup threshold and clamp in upper halves
// - torque integral gain and threshold in one word, clamp in proportional word
// - torque-loop select makes the torque field motor power or proportional gain
// - a 22-bit sync delay precedes a start or stop of the motor when scale is 01 and the delay is nonzero
// - scale 00 disables the sync delay, 01 counts it in nanoseconds, others reserved
// - speed-loop clear forces output to input, zero input gives 120 rpm
// - hold bit stops rotation and holds position while set
// - emergency halt engages brakes at once, without sync delay or commit
// - drive-enable bit turns the motor drivers on and off
// - motion mode selects speed slewing or ramped positioning
// - direction bit selects clockwise or counter-clockwise rotation
// - commit copies all holding registers into active registers, otherwise these stay
// - target-speed register holds the requested speed in its low half
// - target-position register holds a signed 32-bit target in degrees
// - current position is reported as signed 32 bits, read only
// - measured speed is reported as unsigned 16 bits in the low half
// - calibrate bit starts ADC offset calibration, clearing it returns to normal
// - quantity select shows current when clear, voltage when set
// - collector skips settle revolutions, then captures for capture revolutions
// - maintenance status bit 2 reports calibration complete
package motor_regs_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_START_CONFIG = 8'h00;
  localparam logic [7:0] OFS_SPEED_LIMIT = 8'h04;
  localparam logic [7:0] OFS_SPEED_INTEGRAL = 8'h08;
  localparam logic [7:0] OFS_SPEED_PROPORTIONAL = 8'h0c;
  localparam logic [7:0] OFS_TORQUE_INTEGRAL = 8'h10;
  localparam logic [7:0] OFS_TORQUE_PROPORTIONAL = 8'h14;
  localparam logic [7:0] OFS_SYNC_CONTROL = 8'h18;
  localparam logic [7:0] OFS_TARGET_SPEED = 8'h1c;
  localparam logic [7:0] OFS_TARGET_POSITION = 8'h20;
  localparam logic [7:0] OFS_CURRENT_POSITION = 8'h24;
  localparam logic [7:0] OFS_SPEED_STATUS = 8'h28;
  localparam logic [7:0] OFS_LIMIT_STATUS = 8'h2c;
  localparam logic [7:0] OFS_MAINT_MAIN = 8'h30;
  localparam logic [7:0] OFS_MAINT_AUX = 8'h34;
  localparam logic [7:0] OFS_MAINT_STATUS = 8'h38;
  localparam int unsigned REG_COUNT = 15;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // sync-control fields
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_DELAY_MSB = 21;
  localparam int unsigned SYNC_SCALE_LSB = 22;
  localparam logic [1:0] SCALE_DISABLED = 2'h0;
  localparam logic [1:0] SCALE_NANOSEC = 2'h1;
  localparam int unsigned BIT_SPEED_CLEAR = 24;
  localparam int unsigned BIT_HOLD = 25;
  localparam int unsigned BIT_TORQUE_SELECT = 26;
  localparam int unsigned BIT_HALT = 27;
  localparam int unsigned BIT_DRIVE_ENABLE = 28;
  localparam int unsigned BIT_MOTION_MODE = 29;
  localparam int unsigned BIT_DIRECTION = 30;
  localparam int unsigned BIT_COMMIT = 31;

  // ---------------------------------------------------------------
  // maintenance fields
  // ---------------------------------------------------------------
  localparam int unsigned BIT_CALIBRATE = 6;
  localparam int unsigned BIT_QUANTITY = 7;
  localparam int unsigned STAT_DONE = 0;
  localparam int unsigned STAT_BUSY = 1;
  localparam int unsigned STAT_CAL_DONE = 2;
  localparam int unsigned STAT_READY = 3;
  localparam logic [16:0] CAPTURE_ZERO_MEANS = 17'h10000;

  // ---------------------------------------------------------------
  // timing and defaults
  // ---------------------------------------------------------------
  localparam int unsigned CLOCK_MHZ = 100;
  localparam logic [22:0] CLOCK_PERIOD_NS = 23'(1000 / CLOCK_MHZ);
  localparam logic [15:0] SPEED_SEED_DEFAULT_RPM = 16'h0078;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef struct packed {
    logic [15:0] start_speed;
    logic [7:0] stator_pole_count;
    logic [7:0] speed_loop_update_rate;
    logic [15:0] speed_ceiling;
    logic [15:0] speed_integral_gain;
    logic [15:0] speed_antiwindup_threshold;
    logic [15:0] speed_proportional_gain;
    logic [15:0] speed_antiwindup_clamp;
    logic [15:0] torque_integral_gain;
    logic [15:0] torque_antiwindup_threshold;
    logic [15:0] torque_antiwindup_clamp;
    logic torque_loop_select;
    logic [9:0] motor_power;
    logic [15:0] torque_proportional_gain;
    logic speed_loop_clear;
    logic [15:0] speed_loop_seed;
    logic [15:0] target_speed;
    logic [31:0] target_position;
    logic motion_mode_select;
    logic direction_ccw;
  } motor_cfg_t;

  typedef struct packed {
    logic drive_enable;
    logic hold_position;
  } motion_t;

  typedef struct packed {
    logic offset_calibrate;
    logic adc_quantity_select;
    logic [7:0] settle_revolutions;
    logic [16:0] capture_revolutions;
    logic [31:0] aux;
  } maint_cfg_t;

  typedef struct packed {
    logic collect_done;
    logic collect_busy;
    logic collect_ready;
    logic offset_calibrate_done_pulse;
    logic [15:0] rotation_count;
  } maint_stat_t;

endpackage
